//--- design/pgcg_pkg.sv
// Package for the single-channel PWM counter, comparator and output generator.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
package pgcg_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] GEN_CTRL_OFF = 8'h40;  // Generator control bits.
  localparam logic [7:0] RAW_EVT_OFF = 8'h48;  // Raw latched events.
  localparam logic [7:0] MASKED_EVT_OFF = 8'h4C;  // Masked events, write one to clear.
  localparam logic [7:0] RELOAD_OFF = 8'h50;  // Counter reload value.
  localparam logic [7:0] COUNT_OFF = 8'h54;  // Live counter value.
  localparam logic [7:0] CMP_A_OFF = 8'h58;  // Comparator A value.
  localparam logic [7:0] CMP_B_OFF = 8'h5C;  // Comparator B value.
  localparam logic [7:0] OUT_A_CTRL_OFF = 8'h60;  // Output A action fields.

  // ----------------------------------------------------------------------
  // Generator control field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;  // Counter runs while set.
  localparam int CTRL_MODE_BIT = 1;  // Clear: count down; set: count up/down.
  localparam int CTRL_LOAD_UPD_BIT = 3;  // Reload value update mode.
  localparam int CTRL_CMPA_UPD_BIT = 4;  // Comparator A update mode.
  localparam int CTRL_CMPB_UPD_BIT = 5;  // Comparator B update mode.
  localparam int CTRL_W = 6;  // Width of the control register.

  // ----------------------------------------------------------------------
  // Event bit positions
  // ----------------------------------------------------------------------
  localparam int EVT_ZERO_BIT = 0;  // Counter equals zero.
  localparam int EVT_RELOAD_BIT = 1;  // Counter equals reload value.
  localparam int EVT_CMPA_UP_BIT = 2;  // Comparator A match counting up.
  localparam int EVT_CMPA_DN_BIT = 3;  // Comparator A match counting down.
  localparam int EVT_CMPB_UP_BIT = 4;  // Comparator B match counting up.
  localparam int EVT_CMPB_DN_BIT = 5;  // Comparator B match counting down.
  localparam int EVT_W = 6;  // Number of events.

  // ----------------------------------------------------------------------
  // Output action field positions (low bit of each 2-bit field)
  // ----------------------------------------------------------------------
  localparam int ACT_ZERO_LSB = 0;
  localparam int ACT_RELOAD_LSB = 2;
  localparam int ACT_CMPA_UP_LSB = 4;
  localparam int ACT_CMPA_DN_LSB = 6;
  localparam int ACT_CMPB_UP_LSB = 8;
  localparam int ACT_CMPB_DN_LSB = 10;
  localparam int ACT_CTRL_W = 12;  // Width of the action register.

  // ----------------------------------------------------------------------
  // Action codes, direction and reset values
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,  // Leave output unchanged.
    ACT_TOGGLE = 2'h1,  // Invert output.
    ACT_LOW = 2'h2,  // Drive output low.
    ACT_HIGH = 2'h3  // Drive output high.
  } pgcg_act_t;

  typedef enum logic {
    DIR_DOWN = 1'b0,  // Counting toward zero.
    DIR_UP = 1'b1  // Counting toward the reload value.
  } pgcg_dir_t;

  localparam logic [15:0] VALUE_RST = 16'h0000;  // Reset of counter and value registers.
  localparam logic [5:0] EVT_RST = 6'h00;  // Reset of latched events.
  localparam logic [11:0] ACT_CTRL_RST = 12'h000;  // Reset of action register.
  localparam logic [5:0] CTRL_RST = 6'h00;  // Reset of control register.

endpackage

//--- design/pgcg_top.sv
// PWM generator channel: counter, two comparators, output A generator and event status.
// Assumes one 40 MHz clock, a synchronous active-high reset, a classic Wishbone master,
// and sync-update requests and interrupt enables driven by logic on the same clock.
//
// Summary of operation
// - Raw status latches all six events regardless.
// - Event bits: BD5 BU4 AD3 AU2 load1 zero0.
// - Masked status shows latched and enabled events.
// - Writing one clears an enabled event; zero keeps it.
// - Reload after zero, or up/down turnaround limit.
// - Immediate mode applies new load at zero.
// - Sync mode applies at zero after request.
// - Rewrite before update discards older pending value.
// - Counter readable; pulse when counter equals load.
// - Zero pulse whenever the running counter value is zero.
// - Compare pulse on equality, never above load.
// - Comparator A update mode selects immediate/sync.
// - Comparator B follows same policy, own bit.
// - Down mode: four events; up/down: six.
// - Zero/load action beats any compare action.
// - Compare A action beats compare B.
// - Action fields BD BU AD AU load zero.
// - Up compare actions only in up/down mode.
// - Codes: keep, toggle, low, high.
// - Down wraps at zero; up/down bounces.
module pgcg_top #(
  parameter int ADDR_W = 8  // Byte address width seen by the slave.
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Master control and interrupt enables.
  input wire logic sync_update_req_i,
  input wire logic [5:0] event_interrupt_enable_i,
  // Generated PWM output.
  output logic generated_output_a_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The decoder compares eight address bits, so narrower buses cannot reach the map.
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic ack_reg;  // Bus acknowledge, one cycle.
  logic [31:0] rdata_reg;  // Registered read data.
  logic [5:0] ctrl_reg;  // Generator control bits.
  logic [11:0] act_ctrl_reg;  // Output A action fields.
  logic [5:0] raw_evt_reg;  // Latched events.
  logic [15:0] cnt_reg;  // Live counter.
  pgcg_pkg::pgcg_dir_t dir_reg;  // Present counting direction.
  logic out_a_reg;  // Output A level.
  logic [15:0] wval_reg [3];  // Software-written values: reload, cmp A, cmp B.
  logic [15:0] act_val_reg [3];  // Values in use by the counter and comparators.
  logic [2:0] pend_reg;  // A written value waits to be applied.
  logic [2:0] armed_reg;  // A sync request has been seen for the pending value.
  logic [2:0] upd_mode;  // Per value: 0 immediate, 1 synchronous.
  logic [2:0] apply;  // Pending value moves into use this cycle.
  logic [2:0] wr_val;  // Bus writes a value register this cycle.
  logic wr_en;  // A write is taken this cycle.
  logic [7:0] adr;  // Decoded byte address.
  logic [15:0] wmask;  // Byte-lane mask for 16-bit fields.
  logic [15:0] wdata16;  // Lower half of write data.
  logic run;  // Counter is enabled.
  logic updown;  // Up/down mode selected.
  logic at_zero;  // Counter at zero while running.
  logic [15:0] reload_eff;  // Reload value seen at this zero.
  logic [5:0] evt;  // Event pulses this cycle.
  logic match_a;  // Comparator A equality.
  logic match_b;  // Comparator B equality.
  logic [5:0] masked_evt;  // Latched and enabled events.
  logic [5:0] clr_evt;  // Bits cleared by a bus write.
  logic [1:0] act_sel;  // Action chosen for this cycle.

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign adr = wb_adr_i[7:0];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata16 = wb_dat_i[15:0];
  assign wr_val[0] = wr_en && (adr == pgcg_pkg::RELOAD_OFF);
  assign wr_val[1] = wr_en && (adr == pgcg_pkg::CMP_A_OFF);
  assign wr_val[2] = wr_en && (adr == pgcg_pkg::CMP_B_OFF);
  assign masked_evt = raw_evt_reg & event_interrupt_enable_i;
  assign clr_evt = (wr_en && (adr == pgcg_pkg::MASKED_EVT_OFF) && wb_sel_i[0]) ?
                   (wb_dat_i[5:0] & masked_evt) : 6'h00;

  // Acknowledge one cycle after the request and drop it the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Read data is captured as the acknowledge rises; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      case (adr)
        pgcg_pkg::GEN_CTRL_OFF: rdata_reg <= {26'h0, ctrl_reg};
        pgcg_pkg::RAW_EVT_OFF: rdata_reg <= {26'h0, raw_evt_reg};
        pgcg_pkg::MASKED_EVT_OFF: rdata_reg <= {26'h0, masked_evt};
        pgcg_pkg::RELOAD_OFF: rdata_reg <= {16'h0, wval_reg[0]};
        pgcg_pkg::COUNT_OFF: rdata_reg <= {16'h0, cnt_reg};
        pgcg_pkg::CMP_A_OFF: rdata_reg <= {16'h0, wval_reg[1]};
        pgcg_pkg::CMP_B_OFF: rdata_reg <= {16'h0, wval_reg[2]};
        pgcg_pkg::OUT_A_CTRL_OFF: rdata_reg <= {20'h0, act_ctrl_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------------------------------------
  // Control and action registers
  // ----------------------------------------------------------------------
  // Control bits steer counting mode, enable and the three update modes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= pgcg_pkg::CTRL_RST;
    end else if (wr_en && (adr == pgcg_pkg::GEN_CTRL_OFF) && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[5:0];
    end
  end

  // Action fields for output A, twelve bits over two byte lanes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_ctrl_reg <= pgcg_pkg::ACT_CTRL_RST;
    end else if (wr_en && (adr == pgcg_pkg::OUT_A_CTRL_OFF)) begin
      act_ctrl_reg <= (act_ctrl_reg & ~wmask[11:0]) | (wb_dat_i[11:0] & wmask[11:0]);
    end
  end

  assign run = ctrl_reg[pgcg_pkg::CTRL_ENABLE_BIT];
  assign updown = ctrl_reg[pgcg_pkg::CTRL_MODE_BIT];
  assign upd_mode = {ctrl_reg[pgcg_pkg::CTRL_CMPB_UPD_BIT],
                     ctrl_reg[pgcg_pkg::CTRL_CMPA_UPD_BIT],
                     ctrl_reg[pgcg_pkg::CTRL_LOAD_UPD_BIT]};
  assign at_zero = run && (cnt_reg == 16'h0000);

  // ----------------------------------------------------------------------
  // Double-buffered values: reload, comparator A, comparator B
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_shadow
    // A pending value moves into use at zero: at once, or after a sync request.
    assign apply[i] = at_zero && pend_reg[i] &&
                      (!upd_mode[i] || armed_reg[i] || sync_update_req_i);

    // A rewrite replaces the waiting value, so the older one is never used.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wval_reg[i] <= pgcg_pkg::VALUE_RST;
      end else if (wr_val[i]) begin
        wval_reg[i] <= (wval_reg[i] & ~wmask) | (wdata16 & wmask);
      end
    end

    // Pending flag: a fresh write keeps it set even if it lands on the apply edge.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pend_reg[i] <= 1'b0;
      end else if (wr_val[i]) begin
        pend_reg[i] <= 1'b1;
      end else if (apply[i]) begin
        pend_reg[i] <= 1'b0;
      end
    end

    // Arm on a sync request while a value waits; disarm when it is applied.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        armed_reg[i] <= 1'b0;
      end else if (sync_update_req_i && (pend_reg[i] || wr_val[i])) begin
        armed_reg[i] <= !apply[i] || wr_val[i];
      end else if (apply[i]) begin
        armed_reg[i] <= 1'b0;
      end
    end

    // Value in use by the counter or comparator.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        act_val_reg[i] <= pgcg_pkg::VALUE_RST;
      end else if (apply[i]) begin
        act_val_reg[i] <= wval_reg[i];
      end
    end
  end

  // Reload value that takes effect at this very zero.
  assign reload_eff = apply[0] ? wval_reg[0] : act_val_reg[0];

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Down mode wraps from zero to the reload value; up/down mode bounces between them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= pgcg_pkg::VALUE_RST;
      dir_reg <= pgcg_pkg::DIR_DOWN;
    end else if (!run) begin
      dir_reg <= pgcg_pkg::DIR_DOWN;
    end else if (!updown) begin
      dir_reg <= pgcg_pkg::DIR_DOWN;
      if (cnt_reg == 16'h0000) begin
        cnt_reg <= reload_eff;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end else begin
      case (dir_reg)
        pgcg_pkg::DIR_UP: begin
          // Turn around at the reload limit.
          if (cnt_reg >= act_val_reg[0]) begin
            dir_reg <= pgcg_pkg::DIR_DOWN;
            cnt_reg <= (cnt_reg == 16'h0000) ? 16'h0000 : cnt_reg - 16'h0001;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: begin
          // Turn around at zero unless the limit is zero too.
          if (cnt_reg == 16'h0000) begin
            if (reload_eff != 16'h0000) begin
              dir_reg <= pgcg_pkg::DIR_UP;
              cnt_reg <= 16'h0001;
            end
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------
  // Comparators never fire when their value lies above the reload value.
  assign match_a = run && (cnt_reg == act_val_reg[1]) &&
                   (act_val_reg[1] <= act_val_reg[0]);
  assign match_b = run && (cnt_reg == act_val_reg[2]) &&
                   (act_val_reg[2] <= act_val_reg[0]);
  assign evt[pgcg_pkg::EVT_ZERO_BIT] = at_zero;
  assign evt[pgcg_pkg::EVT_RELOAD_BIT] = run && (cnt_reg == act_val_reg[0]);
  assign evt[pgcg_pkg::EVT_CMPA_UP_BIT] = match_a && updown &&
                                          (dir_reg == pgcg_pkg::DIR_UP);
  assign evt[pgcg_pkg::EVT_CMPA_DN_BIT] = match_a && (dir_reg == pgcg_pkg::DIR_DOWN);
  assign evt[pgcg_pkg::EVT_CMPB_UP_BIT] = match_b && updown &&
                                          (dir_reg == pgcg_pkg::DIR_UP);
  assign evt[pgcg_pkg::EVT_CMPB_DN_BIT] = match_b && (dir_reg == pgcg_pkg::DIR_DOWN);

  // Latch events regardless of enables; a new event wins over a clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_evt_reg <= pgcg_pkg::EVT_RST;
    end else begin
      raw_evt_reg <= (raw_evt_reg & ~clr_evt) | evt;
    end
  end

  // ----------------------------------------------------------------------
  // Output A generator
  // ----------------------------------------------------------------------
  // Zero beats load, both beat compares, and compare A beats compare B.
  always_comb begin
    act_sel = 2'h0;
    if (evt[pgcg_pkg::EVT_ZERO_BIT]) begin
      act_sel = act_ctrl_reg[pgcg_pkg::ACT_ZERO_LSB +: 2];
    end else if (evt[pgcg_pkg::EVT_RELOAD_BIT]) begin
      act_sel = act_ctrl_reg[pgcg_pkg::ACT_RELOAD_LSB +: 2];
    end else if (evt[pgcg_pkg::EVT_CMPA_UP_BIT] && updown) begin
      act_sel = act_ctrl_reg[pgcg_pkg::ACT_CMPA_UP_LSB +: 2];
    end else if (evt[pgcg_pkg::EVT_CMPA_DN_BIT]) begin
      act_sel = act_ctrl_reg[pgcg_pkg::ACT_CMPA_DN_LSB +: 2];
    end else if (evt[pgcg_pkg::EVT_CMPB_UP_BIT] && updown) begin
      act_sel = act_ctrl_reg[pgcg_pkg::ACT_CMPB_UP_LSB +: 2];
    end else if (evt[pgcg_pkg::EVT_CMPB_DN_BIT]) begin
      act_sel = act_ctrl_reg[pgcg_pkg::ACT_CMPB_DN_LSB +: 2];
    end
  end

  // Apply the chosen action to the output level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_a_reg <= 1'b0;
    end else begin
      case (pgcg_pkg::pgcg_act_t'(act_sel))
        pgcg_pkg::ACT_TOGGLE: out_a_reg <= !out_a_reg;
        pgcg_pkg::ACT_LOW: out_a_reg <= 1'b0;
        pgcg_pkg::ACT_HIGH: out_a_reg <= 1'b1;
        default: out_a_reg <= out_a_reg;
      endcase
    end
  end

  assign generated_output_a_o = out_a_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Every event pulse is visible in the raw status one cycle later.
  property p_evt_latched;
    @(posedge clk_i) disable iff (rst_i)
      (evt != 6'h00) |=> ((raw_evt_reg & $past(evt)) == $past(evt));
  endproperty
  a_evt_latched: assert property (p_evt_latched) else $error("event not latched");

  // A one written to masked bit 0 (zero event) clears it when no new zero event arrives.
  property p_w1c;
    @(posedge clk_i) disable iff (rst_i)
      (clr_evt[0] && !evt[0]) |=> !raw_evt_reg[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  // Down mode reloads the effective value after zero.
  property p_down_reload;
    @(posedge clk_i) disable iff (rst_i)
      (at_zero && !updown) |=> (cnt_reg == $past(reload_eff)) && (cnt_reg == act_val_reg[0]);
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("reload wrong");

  // Up/down turnaround at the limit steps down.
  property p_turn;
    @(posedge clk_i) disable iff (rst_i)
      (run && updown && dir_reg == pgcg_pkg::DIR_UP && cnt_reg == act_val_reg[0] &&
       cnt_reg != 16'h0000) |=> (dir_reg == pgcg_pkg::DIR_DOWN) &&
      (cnt_reg == $past(cnt_reg) - 16'h0001);
  endproperty
  a_turn: assert property (p_turn) else $error("no turnaround at limit");

  // Comparator A in synchronous mode without any request keeps the old value.
  property p_sync_hold;
    @(posedge clk_i) disable iff (rst_i)
      (upd_mode[1] && !armed_reg[1] && !sync_update_req_i && !wr_val[1]) |=>
      $stable(act_val_reg[1]);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync value applied early");

  // A comparator B value above the reload value never matches.
  property p_no_match;
    @(posedge clk_i) disable iff (rst_i)
      (act_val_reg[2] > act_val_reg[0]) |->
      !evt[pgcg_pkg::EVT_CMPB_UP_BIT] && !evt[pgcg_pkg::EVT_CMPB_DN_BIT];
  endproperty
  a_no_match: assert property (p_no_match) else $error("compare fired above reload");

  // Down mode produces no up-counting events.
  property p_down_four;
    @(posedge clk_i) disable iff (rst_i)
      !updown |-> !evt[pgcg_pkg::EVT_CMPA_UP_BIT] && !evt[pgcg_pkg::EVT_CMPB_UP_BIT];
  endproperty
  a_down_four: assert property (p_down_four) else $error("up event in down mode");

  // Zero action overrides a coinciding compare action.
  property p_zero_wins;
    @(posedge clk_i) disable iff (rst_i)
      (at_zero && act_ctrl_reg[1:0] == 2'h3) |=> generated_output_a_o;
  endproperty
  a_zero_wins: assert property (p_zero_wins) else $error("zero action lost");

  // Compare A action overrides compare B when both match counting down.
  property p_a_wins;
    @(posedge clk_i) disable iff (rst_i)
      (evt[3] && evt[5] && !evt[0] && !evt[1] && act_ctrl_reg[7:6] == 2'h2) |=>
      !generated_output_a_o;
  endproperty
  a_a_wins: assert property (p_a_wins) else $error("compare B beat compare A");

  // After reset the output is low and nothing is latched.
  property p_reset_state;
    @(posedge clk_i) $past(rst_i) |-> !generated_output_a_o && (raw_evt_reg == 6'h00);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

endmodule

//--- tb/pgcg_tb.sv
// Self-checking bench for the PWM counter, comparator and output A generator.
// Assumes pgcg_pkg and pgcg_top are compiled first; the bench is the only bus master.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Signals, counters and reference model state
  // --------------------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, exp_rd;
  logic wb_ack_o, sync_update_req_i = 1'b0, generated_output_a_o, out_m, dir, up, ma, mb;
  logic [5:0] event_interrupt_enable_i = 6'h00, ctl, raw, ev, clr;
  logic [11:0] act;
  logic [15:0] cnt, av[3], pv[3];
  logic pd[3], sn[3];
  int fail_count = 0, checks = 0, j;
  pgcg_top #(.ADDR_W(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sync_update_req_i(sync_update_req_i), .event_interrupt_enable_i(event_interrupt_enable_i),
    .generated_output_a_o(generated_output_a_o));
  // The clock toggles every half period of 12.5 ns.
  always #12.5 clk_i = ~clk_i;
  // Applies one 2-bit action code to the modelled output.
  function automatic logic act_f(input logic [1:0] c, input logic o);
    return (c == 2'h1) ? ~o : (c == 2'h2) ? 1'b0 : (c == 2'h3) ? 1'b1 : o;
  endfunction
  // --------------------------------------------------------------------------
  // Reference model: steps once per edge; the counter step sees values applied at that edge.
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt = 16'h0000; dir = 1'b0; out_m = 1'b0; raw = 6'h00; ctl = 6'h00; act = 12'h000;
      for (int i = 0; i < 3; i++) begin
        av[i] = 16'h0000; pv[i] = 16'h0000; pd[i] = 0; sn[i] = 0;
      end
    end else begin
      up = ctl[1] && dir && (cnt != 16'h0000);
      ev = 6'h00;
      // A comparator whose value lies above the reload value never matches.
      ma = (cnt == av[1]) && (av[1] <= av[0]);
      mb = (cnt == av[2]) && (av[2] <= av[0]);
      if (ctl[0]) ev = {mb && !up, mb && up, ma && !up, ma && up,
        cnt == av[0], cnt == 16'h0000};
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          8'h40: exp_rd = {26'h0, ctl};
          8'h48: exp_rd = {26'h0, raw};
          8'h4C: exp_rd = {26'h0, raw & event_interrupt_enable_i};
          8'h50: exp_rd = {16'h0, pv[0]};
          8'h54: exp_rd = {16'h0, cnt};
          8'h58: exp_rd = {16'h0, pv[1]};
          8'h5C: exp_rd = {16'h0, pv[2]};
          8'h60: exp_rd = {20'h0, act};
          default: exp_rd = 32'h00000000;
        endcase
      end
      if (ev[0]) out_m = act_f(act[1:0], out_m);
      else if (ev[1]) out_m = act_f(act[3:2], out_m);
      else if (ev[2] || ev[3]) out_m = act_f(ev[2] ? act[5:4] : act[7:6], out_m);
      else if (ev[4] || ev[5]) out_m = act_f(ev[4] ? act[9:8] : act[11:10], out_m);
      clr = (wb_ack_o && wb_stb_i && wb_we_i && wb_adr_i == 8'h4C) ?
        wb_dat_i[5:0] & event_interrupt_enable_i : 6'h00;
      raw = (raw & ~clr) | ev;
      for (int i = 0; i < 3; i++) begin
        if (ctl[0] && pd[i] && cnt == 16'h0000 && (!ctl[3+i] || sn[i] || sync_update_req_i)) begin
          av[i] = pv[i]; pd[i] = 0;
        end else if (pd[i] && sync_update_req_i) sn[i] = 1;
      end
      if (!ctl[0]) dir = 1'b0;
      else if (!ctl[1]) cnt = (cnt == 16'h0000) ? av[0] : cnt - 16'h0001;
      else if (dir && cnt >= av[0]) begin dir = 1'b0; cnt = cnt - 16'h0001; end
      else if (dir || cnt == 16'h0000) begin dir = 1'b1; cnt = cnt + 16'h0001; end
      else cnt = cnt - 16'h0001;
      if (wb_ack_o && wb_stb_i && wb_we_i) begin
        case (wb_adr_i)
          8'h40: ctl = wb_dat_i[5:0];
          8'h50, 8'h58, 8'h5C: begin
            // Reload, compare A and compare B slots; the counter offset sits between them.
            j = (wb_adr_i == 8'h50) ? 0 : (wb_adr_i == 8'h58) ? 1 : 2;
            pv[j] = wb_dat_i[15:0];
            pd[j] = 1; sn[j] = 0;
          end
          8'h60: act = wb_dat_i[11:0];
          default: ;
        endcase
      end
    end
  end
  // --------------------------------------------------------------------------
  // Compare, bus and closing tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin fail_count++; $display("BAD %s expected %h seen %h", what, e, g); end
  endtask
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One classic Wishbone cycle; holds everything until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    sync_update_req_i <= 1'b0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= dat;
    for (int n = 0; n <= 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
      if (n == 20) begin fail_count++; end_of_test(); end
    end
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    if (!we) chk("read data", exp_rd, wb_dat_o);
  endtask
  // Output A is compared with the model once per cycle, away from the edge.
  always @(negedge clk_i) begin
    if (!rst_i) chk("output a", {31'h0, out_m}, {31'h0, generated_output_a_o});
  end
  // --------------------------------------------------------------------------
  // Main sequence: reset values, then random rounds in both counting modes
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] rd_list[10];
    void'($urandom(8160));
    rd_list = '{8'h40, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h00, 8'h44};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rd_list[i]) wb(1'b0, rd_list[i], 32'h0);
    wb(1'b1, 8'h48, 32'h0000003F); wb(1'b1, 8'h54, 32'h0000FFFF); wb(1'b1, 8'h44, 32'hFFFFFFFF);
    wb(1'b0, 8'h48, 32'h0); wb(1'b0, 8'h54, 32'h0); wb(1'b0, 8'h44, 32'h0);
    for (int r = 0; r < 8; r++) begin
      wb(1'b1, 8'h50, 32'd9 + $urandom % 16);
      wb(1'b1, 8'h58, 32'd1 + $urandom % 7);
      wb(1'b1, 8'h5C, (r == 3) ? 32'd40 : 32'd1 + $urandom % 7);
      wb(1'b1, 8'h60, {20'h0, 12'($urandom)});
      event_interrupt_enable_i <= 6'($urandom);
      wb(1'b1, 8'h40, {26'h0, (r >= 4) ? 3'($urandom) : 3'h0, 1'b0, r[0], 1'b1});
      for (int k = 0; k < 30; k++) begin
        repeat (3 + $urandom % 3) @(posedge clk_i)
          sync_update_req_i <= (r >= 4) && ($urandom % 9 == 0);
        if (k == 10) begin
          wb(1'b1, 8'h50, 32'd9 + $urandom % 16); wb(1'b1, 8'h50, 32'd9 + $urandom % 16);
          wb(1'b1, 8'h58, 32'd1 + $urandom % 7); wb(1'b1, 8'h5C, 32'd1 + $urandom % 7);
        end
        case ($urandom % 4)
          0: wb(1'b0, 8'h54, 32'h0);
          1: wb(1'b0, 8'h48, 32'h0);
          2: wb(1'b0, 8'h4C, 32'h0);
          default: wb(1'b1, 8'h4C, {26'h0, 6'($urandom)});
        endcase
      end
      wb(1'b1, 8'h40, 32'h0);
    end
    end_of_test();
  end
endmodule
